/* File: pin_partner.sv */
// outside party on the two pins: drives a level when told to, else a pull-up.
// assumes the bench never drives a pin while the design drives it.
module pin_partner (
   // design side
   input wire [1:0] pin_out,
   input wire [1:0] pin_oe,
   // stimulus from the bench
   input wire [1:0] drive_en,
   input wire [1:0] drive_lvl,
   // level seen on the wires
   output wire [1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // wire level: design if enabled, outside driver next, pull-up when floating
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~drive_en) |
                   (~pin_oe & drive_en & drive_lvl);
endmodule // pin_partner

/* File: pwm_gen.v */
// one pwm generator: free-running period counter and active-time compare.
// assumes period and active time are given in core clock cycles.
`include "status_io_defs.vh"

module pwm_gen (
   // clock, reset, enable
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire en,
   // settings in cycles
   input wire [`PWM_W-1:0] period,
   input wire [`PWM_W-1:0] active,
   // logical waveform, 1 during the active part of the period
   output wire wave
);

   reg [`PWM_W-1:0] count_q;
   reg wave_q;
   wire [`PWM_W-1:0] count_inc = count_q + {{(`PWM_W-1){1'b0}}, 1'b1};

   // =======================================================
   // counter wraps at period; a period of zero just idles at zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= {`PWM_W{1'b0}};
         wave_q <= 1'b0;
      end else if (ce) begin
         if (!en || count_inc >= period) begin
            count_q <= {`PWM_W{1'b0}}; // [R13]
         end else begin
            count_q <= count_inc;
         end
         // active >= period gives a steady logical one, unless active is zero
         wave_q <= en && (count_q < active); // [R11]
      end
   end

   assign wave = wave_q;

endmodule // pwm_gen

/* File: status_io_defs.vh */
// constants shared by the status/io pin logic and its pwm generator.
// assumes a 50 MHz core clock and a 32-bit axi4-lite register port.
`ifndef STATUS_IO_DEFS_VH
`define STATUS_IO_DEFS_VH

// ==========================================================
// clock and pwm timing
`define CLK_HZ 50000000
`define PWM_DEF_FREQ_HZ 100
`define PWM_DEF_DUTY_PCT 10
`define PCT_FULL 100
`define PWM_W 24

// ==========================================================
// register byte offsets (each register one aligned word)
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_PERIOD0 8'h04
`define OFS_ACTIVE0 8'h08
`define OFS_PERIOD1 8'h0c
`define OFS_ACTIVE1 8'h10
`define OFS_STATUS 8'h14

// ==========================================================
// control fields, one byte lane per pin
`define LANE_W 8
`define FN_LSB 0
`define FN_MSB 1
`define INV_BIT 2
`define SEL_LSB 3
`define SEL_MSB 4
`define CTRL_FIELD_W 5
`define CTRL_PAD 3'h0
`define CTRL_RST 5'h00

// pin functions
`define FN_STATUS 2'h0
`define FN_INPUT 2'h1
`define FN_OUTPUT 2'h2

// general output values
`define SEL_ZERO 2'h0
`define SEL_ONE 2'h1
`define SEL_PWM 2'h2

// ==========================================================
// status register fields
`define STS_IN_LSB 0
`define STS_PIN_LSB 4
`define STS_OE_LSB 8
`define STS_PROT_BIT 12
`define STS_ON_BIT 13

// ==========================================================
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h0000_0000

`endif

/* File: status_io_pin_logic.v */
// logic behind two configurable status/io pins with an axi4-lite register port.
// assumes protection_active and output_on are synchronous to core_clk;
// the pin inputs come from outside and are synchronised here.
//
// How it works
// [R1] pin 0 is protection status output, level input or general output.
// [R2] pin 1 is output-off status, level input or general output.
// [R3] each pin has a polarity bit, normal at reset, reversing in and out.
// [R4] protection status normal: pin high when unprotected, low when protected.
// [R5] reversed polarity on a status function drives the opposite level.
// [R6] output-off status normal: pin high while main output is off.
// [R7] output-off status normal: pin low while main output is on.
// [R8] general output drives constant one, constant zero or pwm.
// [R9] logical one is pin low when normal, high when reversed.
// [R10] logical zero is pin high when normal, low when reversed.
// [R11] pwm waveform takes period and active time from two settings.
// [R12] in input function the outside drives the pin and we sample it.
// [R13] period setting fixes pwm period, active setting its active share.
// [R14] one clock; reset gives status function, normal polarity; inputs double-synced.
// [R15] status levels follow protection or on/off state within one cycle.
`include "status_io_defs.vh"

module status_io_pin_logic (
   // clock, reset, enable
   input wire core_clk,
   input wire nrst,
   input wire ce,
   // instrument state
   input wire protection_active,
   input wire output_on,
   // pins, split into level in, level out and output enable
   input wire [1:0] pin_in,
   output wire [1:0] pin_out,
   output wire [1:0] pin_oe,
   // axi4-lite write address
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);

   // pwm defaults: 100 Hz period, 10 percent active
   // worked out at integer width, then cut to the counter width on purpose
   localparam integer PERIOD_CNT = `CLK_HZ / `PWM_DEF_FREQ_HZ;
   localparam integer ACTIVE_CNT = PERIOD_CNT / `PCT_FULL * `PWM_DEF_DUTY_PCT;
   localparam [`PWM_W-1:0] PERIOD_RST = PERIOD_CNT[`PWM_W-1:0];
   localparam [`PWM_W-1:0] ACTIVE_RST = ACTIVE_CNT[`PWM_W-1:0];

   // =======================================================
   // reset release: asserted at once, released after two edges
   reg rst_s1_q;
   reg rst_n_q;

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else if (ce) begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // =======================================================
   // byte-lane merge for partial writes
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      integer b;
      begin
         merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[8*b +: 8] = new_v[8*b +: 8];
            end
         end
      end
   endfunction

   // =======================================================
   // axi write channel: address and data taken in either order
   reg awready_q;
   reg wready_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg aw_have_q;
   reg w_have_q;
   reg [`ADDR_W-1:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
   wire [`ADDR_W-1:0] waddr_al = {waddr_q[`ADDR_W-1:2], 2'b00};
   wire wr_hit = (waddr_al == `OFS_CTRL) || (waddr_al == `OFS_PERIOD0) ||
                 (waddr_al == `OFS_ACTIVE0) || (waddr_al == `OFS_PERIOD1) ||
                 (waddr_al == `OFS_ACTIVE1);

   // status is read-only, so a write to it answers slverr like a hole
   always @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= {`ADDR_W{1'b0}};
         wdata_q <= `DATA_ZERO;
         wstrb_q <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // =======================================================
   // per-pin configuration, synchroniser, pwm and pin driver
   wire [1:0] status_src = {~output_on, ~protection_active}; // [R4] [R6] [R7]
   wire [2*`LANE_W-1:0] ctrl_w;
   wire [2*`PWM_W-1:0] period_w;
   wire [2*`PWM_W-1:0] active_w;
   wire [1:0] in_w;
   wire [1:0] out_w;
   wire [1:0] oe_w;

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : pin_g
         localparam [`ADDR_W-1:0] PER_OFS = (p == 0) ? `OFS_PERIOD0 : `OFS_PERIOD1;
         localparam [`ADDR_W-1:0] ACT_OFS = (p == 0) ? `OFS_ACTIVE0 : `OFS_ACTIVE1;
         reg [1:0] fn_q;
         reg inv_q;
         reg [1:0] sel_q;
         reg [`PWM_W-1:0] period_q;
         reg [`PWM_W-1:0] active_q;
         reg sync1_q;
         reg sync2_q;
         reg out_q;
         reg oe_q;
         wire wave;
         wire [31:0] per_m = merge({8'h00, period_q}, wdata_q, wstrb_q);
         wire [31:0] act_m = merge({8'h00, active_q}, wdata_q, wstrb_q);
         wire [`LANE_W-1:0] lane = wdata_q[`LANE_W*p +: `LANE_W];
         wire logic_val = (sel_q == `SEL_ONE) ? 1'b1 :
                          (sel_q == `SEL_PWM) ? wave : 1'b0; // [R8]

         // configuration written from the completed write
         always @(posedge core_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               fn_q <= `FN_STATUS; // [R14]
               inv_q <= 1'b0; // [R14]
               sel_q <= `SEL_ZERO;
               period_q <= PERIOD_RST;
               active_q <= ACTIVE_RST;
            end else if (ce && wr_fire) begin
               if (waddr_al == `OFS_CTRL && wstrb_q[p]) begin
                  fn_q <= lane[`FN_MSB:`FN_LSB]; // [R1] [R2]
                  inv_q <= lane[`INV_BIT]; // [R3]
                  sel_q <= lane[`SEL_MSB:`SEL_LSB];
               end
               if (waddr_al == PER_OFS) begin
                  period_q <= per_m[`PWM_W-1:0]; // [R13]
               end
               if (waddr_al == ACT_OFS) begin
                  active_q <= act_m[`PWM_W-1:0]; // [R13]
               end
            end
         end

         // two-stage synchroniser on the pin level
         always @(posedge core_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               sync1_q <= 1'b0;
               sync2_q <= 1'b0;
            end else if (ce) begin
               sync1_q <= pin_in[p]; // [R14]
               sync2_q <= sync1_q; // [R12]
            end
         end

         pwm_gen u_pwm (
            .clk(core_clk),
            .rst_n(rst_n_q),
            .ce(ce),
            .en((fn_q == `FN_OUTPUT) && (sel_q == `SEL_PWM)),
            .period(period_q),
            .active(active_q),
            .wave(wave)
         );

         // pin driver; registered so the pin moves one edge after its cause.
         // reserved function code 3 releases the pin like input mode.
         always @(posedge core_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               out_q <= 1'b0;
               oe_q <= 1'b0;
            end else if (ce) begin
               case (fn_q)
                  `FN_STATUS: begin
                     out_q <= status_src[p] ^ inv_q; // [R5] [R15]
                     oe_q <= 1'b1;
                  end
                  `FN_OUTPUT: begin
                     out_q <= ~logic_val ^ inv_q; // [R9] [R10]
                     oe_q <= 1'b1;
                  end
                  `FN_INPUT: begin
                     out_q <= 1'b0;
                     oe_q <= 1'b0; // [R12]
                  end
                  default: begin
                     out_q <= 1'b0;
                     oe_q <= 1'b0;
                  end
               endcase
            end
         end

         assign ctrl_w[`LANE_W*p +: `LANE_W] = {`CTRL_PAD, sel_q, inv_q, fn_q};
         assign period_w[`PWM_W*p +: `PWM_W] = period_q;
         assign active_w[`PWM_W*p +: `PWM_W] = active_q;
         assign in_w[p] = sync2_q ^ inv_q; // [R3]
         assign out_w[p] = out_q;
         assign oe_w[p] = oe_q;
      end
   endgenerate

   assign pin_out = out_w;
   assign pin_oe = oe_w;

   // =======================================================
   // axi read channel: one read at a time, data registered
   reg arready_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg [31:0] rd_val;
   reg rd_ok;
   wire [`ADDR_W-1:0] raddr_al = {s_axi_araddr[`ADDR_W-1:2], 2'b00};

   // read decode; bits beyond each field read as zero
   always @* begin
      rd_val = `DATA_ZERO;
      rd_ok = 1'b1;
      case (raddr_al)
         `OFS_CTRL: rd_val = {16'h0000, ctrl_w};
         `OFS_PERIOD0: rd_val = {8'h00, period_w[`PWM_W-1:0]};
         `OFS_ACTIVE0: rd_val = {8'h00, active_w[`PWM_W-1:0]};
         `OFS_PERIOD1: rd_val = {8'h00, period_w[2*`PWM_W-1:`PWM_W]};
         `OFS_ACTIVE1: rd_val = {8'h00, active_w[2*`PWM_W-1:`PWM_W]};
         `OFS_STATUS: begin
            rd_val[`STS_IN_LSB +: 2] = in_w;
            rd_val[`STS_PIN_LSB +: 2] = out_w;
            rd_val[`STS_OE_LSB +: 2] = oe_w;
            rd_val[`STS_PROT_BIT] = protection_active;
            rd_val[`STS_ON_BIT] = output_on;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= `DATA_ZERO;
         rresp_q <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule // status_io_pin_logic

/* File: status_io_pin_logic_properties.sv */
// checker for the status/io pin logic: pin levels after reset and bus handshakes.
// assumes ce drops only while the bus is idle; bound to every status_io_pin_logic instance.
`include "status_io_defs.vh"

module status_io_checker (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   // instrument state and pins
   input wire protection_active,
   input wire output_on,
   input wire [1:0] pin_out,
   input wire [1:0] pin_oe,
   // bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic dflt_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ==========
   // helper: config is known to be the default until the first write is taken
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dflt_q <= 1'h1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         dflt_q <= 1'h0;
      end
   end

   // ==========
   // pin levels
   property p_rst_status;
      $rose(nrst) |-> ##[2:4] pin_oe == 2'h3;
   endproperty
   a_rst_status: assert property (p_rst_status) else $error("pins not driven after reset");
   property p_dflt;
      dflt_q && pin_oe == 2'h3 |-> pin_out == {~$past(output_on), ~$past(protection_active)};
   endproperty
   a_dflt: assert property (p_dflt) else $error("status level wrong");
   property p_undriven;
      (pin_out & ~pin_oe) == 2'h0;
   endproperty
   a_undriven: assert property (p_undriven) else $error("level on undriven pin");

   // ==========
   // bus handshakes
   property p_aw_take;
      // pair is registered at the take, the response one edge after that
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_aw_take: assert property (p_aw_take) else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy: assert property (p_busy) else $error("write taken while busy");
   property p_ar_take;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ar_take: assert property (p_ar_take) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == `DATA_ZERO;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
endmodule // status_io_checker

bind status_io_pin_logic status_io_checker u_chk (.core_clk, .nrst, .protection_active,
   .output_on, .pin_out, .pin_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: testbench.sv */
// self-checking bench for status_io_pin_logic with an outside pin partner.
// assumes the design files and status_io_defs.vh are compiled before it.
`include "status_io_defs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
$display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // signals; rows hold {ctrl byte, 2'b00, prot, on, pin_out, pin_oe}
   logic core_clk = 0, nrst = 0, protection_active = 0, output_on = 0, ce = 1;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] pin_in, pin_out, pin_oe, drive_en = 0, drive_lvl = 0, bresp, rresp, r;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
   logic arvalid = 0, arready, rvalid, rready = 0;
   int miscompares = 0, check_count = 0, cyc = 0, lo;
   bit [15:0] rows [12] = '{16'h000f, 16'h0033, 16'h002b, 16'h0017, 16'h0403, 16'h043f,
      16'h0100, 16'h0300, 16'h020f, 16'h0a03, 16'h0603, 16'h0e0f};

   status_io_pin_logic dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .protection_active(protection_active), .output_on(output_on), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   pin_partner far (.pin_out(pin_out), .pin_oe(pin_oe), .drive_en(drive_en),
      .drive_lvl(drive_lvl), .pin_in(pin_in));

   // ==========
   // clock and hang guard
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (++cyc == 5000) begin
         miscompares++;
         wrap_up;
      end
   end

   // ==========
   // tasks; axw and axr each start a clock later so no strobe is set twice in one step
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic do_reset;
      nrst <= 0;
      repeat (4) @(posedge core_clk);
      nrst <= 1;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic axw(input [7:0] a, input [31:0] v);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask
   task automatic axr(input [7:0] a);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   // ==========
   // main sequence
   initial begin
      do_reset;
      axr(`OFS_CTRL);
      `CHK(d, `DATA_ZERO);
      axr(`OFS_PERIOD0);
      `CHK(d, 32'h0007_a120);
      axr(`OFS_ACTIVE1);
      `CHK(d, 32'h0000_c350);
      // same function on both pins, state inputs set beside it
      foreach (rows[i]) begin
         // state inputs move right at an edge, never off a sampling point
         @(posedge core_clk);
         protection_active <= rows[i][5];
         output_on <= rows[i][4];
         axw(`OFS_CTRL, {16'h0000, rows[i][15:8], rows[i][15:8]});
         `CHK(r, `RESP_OKAY);
         tk(3);
         `CHK({pin_out, pin_oe}, rows[i][3:0]);
      end
      // level input, pin 1 reversed; outside drives pin 0 high, pin 1 low,
      // so the result differs from what the pull-up alone would give
      axw(`OFS_CTRL, 32'h0000_0501);
      drive_en <= 2'h3;
      drive_lvl <= 2'h1;
      tk(4);
      axr(`OFS_STATUS);
      `CHK({d[9:8], d[5:4], d[1:0]}, 6'h03);
      drive_en <= 2'h0;
      // pwm on pin 0: period 10, active 3, so 6 active cycles in any 20
      axw(`OFS_PERIOD0, 32'h0000_000a);
      axw(`OFS_ACTIVE0, 32'h0000_0003);
      for (int k = 0; k < 2; k++) begin
         axw(`OFS_CTRL, k ? 32'h0000_0016 : 32'h0000_0012);
         tk(4);
         lo = 0;
         repeat (20) begin
            lo += (pin_out[0] === k[0]);
            tk(1);
         end
         `CHK(lo, 6);
      end
      // ce low freezes the running pwm; longer than a period, so a moving pin shows
      @(posedge core_clk);
      ce <= 0;
      tk(1);
      lo = pin_out[0];
      repeat (15) begin
         tk(1);
         `CHK(pin_out[0], lo[0]);
      end
      @(posedge core_clk);
      ce <= 1;
      // refused places: unmapped and read-only
      axw(8'h18, 32'h0000_0001);
      `CHK(r, `RESP_SLVERR);
      axw(`OFS_STATUS, 32'h0000_0001);
      `CHK(r, `RESP_SLVERR);
      axr(8'h18);
      `CHK({r, d}, {`RESP_SLVERR, `DATA_ZERO});
      // partial write: only the low byte of the pin 1 period changes
      wstrb <= 4'h1;
      axw(`OFS_PERIOD1, 32'h0000_00aa);
      `CHK(r, `RESP_OKAY);
      wstrb <= 4'hf;
      axr(`OFS_PERIOD1);
      `CHK(d, 32'h0007_a1aa);
      // second reset mid-run must bring back the status functions
      do_reset;
      protection_active <= 1;
      output_on <= 1;
      tk(3);
      `CHK({pin_out, pin_oe}, 4'h3);
      axr(`OFS_CTRL);
      `CHK(d, `DATA_ZERO);
      wrap_up;
   end
endmodule // testbench
